// ==== design/adcc_consts.svh ====
// Constants for the converter control block: offsets, fields, resets and timing.
// How it works
// - Two-channel mode uses auto channel select registers.
// - Blanking register holds mode, auto start, blanking time.
// - Programmable delay between first and second channel.
// - Converter pin drops I/O function and pull-high.
// - Manual start needs mode 00 and high-then-low.
// - Busy sets on start sequence or blanking fall.
// - Busy clears when conversion completes.
// - Enable bit 0 powers converter off.
// - Disabled converter leaves result registers unchanged.
// - Format bit writable only in mode 00.
// - Format 0 left-justified, format 1 right-justified.
// - Nonzero mode forces format bit to 1.
// - Codes 0-7 select inputs, 8-15 float.
// - Unused result bits read as zero.
// - Internal source disconnects external channel input.
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH
`define ADCC_OFS_CTRL0 8'h00
`define ADCC_OFS_CTRL1 8'h04
`define ADCC_OFS_BLANK 8'h08
`define ADCC_OFS_ACH1 8'h0c
`define ADCC_OFS_ACH2 8'h10
`define ADCC_OFS_ADLY 8'h14
`define ADCC_OFS_RHIGH 8'h18
`define ADCC_OFS_RLOW 8'h1c
`define ADCC_OFS_BUF1 8'h20
`define ADCC_OFS_BUF2 8'h24
`define ADCC_OFS_IRQ_STAT 8'h28
`define ADCC_OFS_IRQ_EN 8'h2c
`define ADCC_OFS_IRQ_CLR 8'h30
`define ADCC_CTRL0_RESET 8'h00
`define ADCC_BIT_START 7
`define ADCC_BIT_BUSY 6
`define ADCC_BIT_ENABLE 5
`define ADCC_BIT_FORMAT 4
`define ADCC_BIT_AUTO_GO 7
`define ADCC_BIT_TWO_CH 5
`define ADCC_CONV_CYCLES 16
`define ADCC_DLY_UNIT 16
`define ADCC_IRQ_W 3
`define ADCC_IRQ_DONE 0
`define ADCC_IRQ_AUTO 1
`define ADCC_IRQ_IGNORED 2
`endif

// ==== design/adcc_pkg.sv ====
// Types shared by the converter control block.
package adcc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_DELAY
  } adcc_state_e;
  typedef struct packed {
    logic [2:0] int_sel;
    logic [3:0] ext_sel;
    logic ext_connect;
    logic [7:0] pin_adc;
  } adcc_mux_s;
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] blank;
    logic [7:0] ach1;
    logic [7:0] ach2;
    logic [7:0] adly;
    logic [7:0] rhigh;
    logic [7:0] rlow;
    logic [15:0] buf1;
    logic [15:0] buf2;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic start_d;
    logic blank_d;
    adcc_state_e state;
    logic second;
    logic [7:0] cnt;
    logic [2:0] runs;
    logic ack;
    logic [31:0] rdata;
  } adcc_state_s;
endpackage

// ==== design/adcc_mux.sv ====
// Input selection for the shared converter core.
`timescale 1ns/1ps
`default_nettype none
module adcc_mux
  import adcc_pkg::*;
(
  input wire logic two_ch,
  input wire logic second,
  input wire logic [7:0] ctrl0,
  input wire logic [7:0] ctrl1,
  input wire logic [7:0] ach1,
  input wire logic [7:0] ach2,
  input wire logic [7:0] pin_adc_cfg,
  output adcc_mux_s mux
);
  logic [3:0] ext;
  logic [2:0] ins;
  logic ext_src;
  always_comb begin
    if (two_ch) begin
      // The source bit picks external or internal source per channel.
      ext = second ? ach2[3:0] : ach1[3:0];
      ins = (second ? ach2[4] : ach1[4]) ? 3'h1 : 3'h0;
    end else begin
      ext = ctrl0[3:0];
      ins = ctrl1[7:5];
    end
  end
  // Codes 1 to 4 are internal or ground; the external path stays off then.
  assign ext_src = (ins == 3'h0) || (ins > 3'h4);
  assign mux.int_sel = ins;
  assign mux.ext_sel = ext;
  assign mux.ext_connect = ext_src && !ext[3];
  // A pin claimed by the converter loses its port function and pull-high.
  assign mux.pin_adc = pin_adc_cfg;
endmodule
`default_nettype wire

// ==== design/adcc_top.sv ====
// Converter control registers, sequencer and Wishbone slave.
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"
module adcc_top
  import adcc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic BLANK_IN,
  input wire logic [11:0] CORE_RESULT,
  input wire logic [7:0] PIN_ADC_CFG,
  output logic CORE_POWER_EN,
  output logic CORE_START,
  output logic [2:0] INT_SIGNAL_SEL,
  output logic [3:0] EXT_CHANNEL_SEL,
  output logic EXT_CONNECT,
  output logic [7:0] PIN_IO_DISCONNECT,
  output logic [7:0] PIN_PULLHIGH_OFF,
  output logic IRQ
);
  adcc_state_s s_r;
  adcc_state_s s_nxt;
  adcc_mux_s mux;
  logic req;
  logic wr;
  logic [11:0] res;
  logic two_ch;
  logic [7:0] dly_cycles;
  logic [2:0] n_runs;
  logic [2:0] ev;
  logic man_start;
  logic auto_start;
  assign req = WB_CYC_I && WB_STB_I && !s_r.ack;
  assign wr = req && WB_WE_I && WB_SEL_I[0];
  assign two_ch = s_r.ach1[`ADCC_BIT_TWO_CH];
  assign res = CORE_RESULT;
  assign dly_cycles = 8'(s_r.adly[3:0]) * 8'(`ADCC_DLY_UNIT);
  always_comb begin
    case (s_r.blank[6:5])
      2'h1: n_runs = 3'h1;
      2'h2: n_runs = 3'h2;
      2'h3: n_runs = 3'h4;
      default: n_runs = 3'h0;
    endcase
  end
  // Start edge is seen on the registered bit, so one write high then low fires once.
  assign man_start = s_r.start_d && !s_r.ctrl0[`ADCC_BIT_START]
    && (s_r.blank[6:5] == 2'h0) && s_r.ctrl0[`ADCC_BIT_ENABLE];
  assign auto_start = s_r.blank_d && !BLANK_IN && s_r.blank[`ADCC_BIT_AUTO_GO]
    && (s_r.blank[6:5] != 2'h0) && s_r.ctrl0[`ADCC_BIT_ENABLE];
  adcc_mux u_mux (
    .two_ch(two_ch),
    .second(s_r.second),
    .ctrl0(s_r.ctrl0),
    .ctrl1(s_r.ctrl1),
    .ach1(s_r.ach1),
    .ach2(s_r.ach2),
    .pin_adc_cfg(PIN_ADC_CFG),
    .mux(mux)
  );
  always_comb begin
    s_nxt = s_r;
    ev = 3'h0;
    s_nxt.ack = req;
    s_nxt.start_d = s_r.ctrl0[`ADCC_BIT_START];
    s_nxt.blank_d = BLANK_IN;
    if (wr) begin
      case (WB_ADR_I)
        `ADCC_OFS_CTRL0: begin
          // Busy is read-only; format only changes in manual mode.
          s_nxt.ctrl0[7] = WB_DAT_I[7];
          s_nxt.ctrl0[5] = WB_DAT_I[5];
          s_nxt.ctrl0[3:0] = WB_DAT_I[3:0];
          if (s_r.blank[6:5] == 2'h0) begin
            s_nxt.ctrl0[`ADCC_BIT_FORMAT] = WB_DAT_I[4];
          end
        end
        `ADCC_OFS_CTRL1: s_nxt.ctrl1 = WB_DAT_I[7:0];
        `ADCC_OFS_BLANK: s_nxt.blank = WB_DAT_I[7:0];
        `ADCC_OFS_ACH1: s_nxt.ach1 = {2'h0, WB_DAT_I[5:0]};
        `ADCC_OFS_ACH2: s_nxt.ach2 = {3'h0, WB_DAT_I[4:0]};
        `ADCC_OFS_ADLY: s_nxt.adly = {4'h0, WB_DAT_I[3:0]};
        `ADCC_OFS_IRQ_EN: s_nxt.irq_en = WB_DAT_I[2:0];
        `ADCC_OFS_IRQ_CLR: s_nxt.irq_stat = s_r.irq_stat & ~WB_DAT_I[2:0];
        default: ;
      endcase
    end
    if (s_nxt.blank[6:5] != 2'h0) begin
      s_nxt.ctrl0[`ADCC_BIT_FORMAT] = 1'b1;
    end
    if (s_r.start_d && !s_r.ctrl0[`ADCC_BIT_START] && !man_start) begin
      ev[`ADCC_IRQ_IGNORED] = 1'b1;
    end
    case (s_r.state)
      ST_IDLE: begin
        s_nxt.second = 1'b0;
        if (man_start || auto_start) begin
          s_nxt.state = ST_CONV;
          s_nxt.cnt = 8'(`ADCC_CONV_CYCLES);
          s_nxt.ctrl0[`ADCC_BIT_BUSY] = 1'b1;
        end
      end
      ST_CONV: begin
        if (!s_r.ctrl0[`ADCC_BIT_ENABLE]) begin
          // Abort leaves the old results in place.
          s_nxt.state = ST_IDLE;
          s_nxt.ctrl0[`ADCC_BIT_BUSY] = 1'b0;
        end else if (s_r.cnt > 8'h1) begin
          s_nxt.cnt = s_r.cnt - 8'h1;
        end else begin
          if (s_r.ctrl0[`ADCC_BIT_FORMAT]) begin
            s_nxt.rhigh = {4'h0, res[11:8]};
            s_nxt.rlow = res[7:0];
          end else begin
            s_nxt.rhigh = res[11:4];
            s_nxt.rlow = {res[3:0], 4'h0};
          end
          ev[`ADCC_IRQ_DONE] = 1'b1;
          if (s_r.blank[6:5] != 2'h0) begin
            if (s_r.second) begin
              s_nxt.buf2 = {4'h0, res};
            end else begin
              s_nxt.buf1 = {4'h0, res};
            end
          end
          if (s_r.blank[6:5] != 2'h0 && two_ch && !s_r.second) begin
            s_nxt.state = ST_DELAY;
            s_nxt.second = 1'b1;
            s_nxt.cnt = dly_cycles;
          end else begin
            s_nxt.state = ST_IDLE;
            s_nxt.ctrl0[`ADCC_BIT_BUSY] = 1'b0;
            if (s_r.blank[6:5] != 2'h0) begin
              if (s_r.runs + 3'h1 >= n_runs) begin
                s_nxt.runs = 3'h0;
                s_nxt.blank[`ADCC_BIT_AUTO_GO] = 1'b0;
                ev[`ADCC_IRQ_AUTO] = 1'b1;
              end else begin
                s_nxt.runs = s_r.runs + 3'h1;
              end
            end
          end
        end
      end
      ST_DELAY: begin
        if (s_r.cnt != 8'h0) begin
          s_nxt.cnt = s_r.cnt - 8'h1;
        end else begin
          s_nxt.state = ST_CONV;
          s_nxt.cnt = 8'(`ADCC_CONV_CYCLES);
        end
      end
      default: s_nxt.state = ST_IDLE;
    endcase
    // A new event wins over a clear written in the same cycle.
    s_nxt.irq_stat = s_nxt.irq_stat | ev;
    case (WB_ADR_I)
      `ADCC_OFS_CTRL0: s_nxt.rdata = {24'h0, s_r.ctrl0};
      `ADCC_OFS_CTRL1: s_nxt.rdata = {24'h0, s_r.ctrl1};
      `ADCC_OFS_BLANK: s_nxt.rdata = {24'h0, s_r.blank};
      `ADCC_OFS_ACH1: s_nxt.rdata = {24'h0, s_r.ach1};
      `ADCC_OFS_ACH2: s_nxt.rdata = {24'h0, s_r.ach2};
      `ADCC_OFS_ADLY: s_nxt.rdata = {24'h0, s_r.adly};
      `ADCC_OFS_RHIGH: s_nxt.rdata = {24'h0, s_r.rhigh};
      `ADCC_OFS_RLOW: s_nxt.rdata = {24'h0, s_r.rlow};
      `ADCC_OFS_BUF1: s_nxt.rdata = {16'h0, s_r.buf1};
      `ADCC_OFS_BUF2: s_nxt.rdata = {16'h0, s_r.buf2};
      `ADCC_OFS_IRQ_STAT: s_nxt.rdata = {29'h0, s_r.irq_stat};
      `ADCC_OFS_IRQ_EN: s_nxt.rdata = {29'h0, s_r.irq_en};
      default: s_nxt.rdata = 32'h0;
    endcase
  end
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign WB_ACK_O = s_r.ack;
  assign WB_DAT_O = s_r.rdata;
  assign CORE_POWER_EN = s_r.ctrl0[`ADCC_BIT_ENABLE];
  assign CORE_START = (s_r.state == ST_CONV) && (s_r.cnt == 8'(`ADCC_CONV_CYCLES));
  assign INT_SIGNAL_SEL = mux.int_sel;
  assign EXT_CHANNEL_SEL = mux.ext_sel;
  assign EXT_CONNECT = mux.ext_connect;
  assign PIN_IO_DISCONNECT = mux.pin_adc;
  assign PIN_PULLHIGH_OFF = mux.pin_adc;
  assign IRQ = |(s_r.irq_stat & s_r.irq_en);

  property p_busy_on_start;
    @(posedge SYS_CLK) disable iff (RST)
    man_start && s_r.state == ST_IDLE |=> s_r.ctrl0[`ADCC_BIT_BUSY];
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("busy not set");
  property p_busy_clear;
    @(posedge SYS_CLK) disable iff (RST)
    s_r.state == ST_CONV && s_r.cnt == 8'h1 && CORE_POWER_EN && !two_ch
      |=> !s_r.ctrl0[`ADCC_BIT_BUSY];
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared");
  property p_no_start_auto;
    @(posedge SYS_CLK) disable iff (RST)
    s_r.blank[6:5] != 2'h0 && s_r.state == ST_IDLE && !auto_start |=> s_r.state == ST_IDLE;
  endproperty
  a_no_start_auto: assert property (p_no_start_auto) else $error("bad start");
  property p_format_forced;
    @(posedge SYS_CLK) disable iff (RST)
    s_r.blank[6:5] != 2'h0 |-> s_r.ctrl0[`ADCC_BIT_FORMAT];
  endproperty
  a_format_forced: assert property (p_format_forced) else $error("format not forced");
  property p_res_hold;
    @(posedge SYS_CLK) disable iff (RST)
    !CORE_POWER_EN |=> $stable(s_r.rhigh) && $stable(s_r.rlow);
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("result changed");
  property p_zero_bits;
    @(posedge SYS_CLK) disable iff (RST)
    $past(s_r.ctrl0[`ADCC_BIT_FORMAT]) && $changed(s_r.rhigh) |-> s_r.rhigh[7:4] == 4'h0;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bits set");
  property p_ext_off;
    @(posedge SYS_CLK) disable iff (RST)
    INT_SIGNAL_SEL inside {3'h1, 3'h2, 3'h3, 3'h4} |-> !EXT_CONNECT;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("external left on");
  property p_float;
    @(posedge SYS_CLK) disable iff (RST)
    EXT_CHANNEL_SEL[3] |-> !EXT_CONNECT;
  endproperty
  a_float: assert property (p_float) else $error("floating code connected");
endmodule
`default_nettype wire

// ==== tb/adcc_core_model.sv ====
// Behavioural model of the shared converter core behind the control block.
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
  input wire logic clk,
  input wire logic power_en,
  input wire logic start,
  output logic [11:0] result
);
  int seed = 32'h0992;
  initial result = 12'h5a5;
  always @(posedge clk) begin
    // A core that is switched off shows garbage, so a stray load is caught.
    if (!power_en) begin
      result <= ~result;
    end else if (start) begin
      result <= 12'($random(seed));
    end
  end
endmodule
`default_nettype wire

// ==== tb/adc_control_register_logic_test.sv ====
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t mismatch", $time); end end
module adc_control_register_logic_test;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, blank = 0;
  logic [7:0] adr = 0, pin = 0;
  logic [31:0] wdat = 0, q, dat_o;
  logic [11:0] res;
  logic ack, pwr, cstart, econ, irq;
  logic [2:0] isel;
  logic [3:0] esel;
  logic [7:0] iod, puo;
  int seed = 32'h0992, num_errors = 0, checks_done = 0, starts = 0, cyc_n = 0;
  logic [3:0] ch_at [16];
  int t_at [16];
  always #4 clk = ~clk;
  adcc_top dut (.SYS_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .BLANK_IN(blank), .CORE_RESULT(res), .PIN_ADC_CFG(pin), .CORE_POWER_EN(pwr),
    .CORE_START(cstart), .INT_SIGNAL_SEL(isel), .EXT_CHANNEL_SEL(esel), .EXT_CONNECT(econ),
    .PIN_IO_DISCONNECT(iod), .PIN_PULLHIGH_OFF(puo), .IRQ(irq));
  adcc_core_model core (.clk(clk), .power_en(pwr), .start(cstart), .result(res));
  task automatic end_of_test;
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = dat_o;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  task automatic conv(input logic [7:0] c);
    wb(1, 8'h00, {24'h0, c | 8'h80});
    wb(1, 8'h00, {24'h0, c});
  endtask
  function automatic logic [15:0] fmt(input logic f, input logic [11:0] r);
    return f ? {4'h0, r} : {r, 4'h0};
  endfunction
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cstart === 1'b1) begin
      ch_at[starts[3:0]] <= esel;
      t_at[starts[3:0]] <= cyc_n;
      starts <= starts + 1;
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test;
  end
  initial begin
    logic [7:0] c, c1;
    logic [3:0] e;
    logic [15:0] x;
    int s0;
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      wb(0, (i == 3) ? 8'hfc : 8'(i * 4), 0);
      `CHK(q, 32'h0)
    end
    wb(1, 8'h00, 32'h40);
    wb(0, 8'h00, 0);
    `CHK(q, 32'h0)
    for (int i = 0; i < 10; i++) begin
      c1 = (i == 0) ? 8'h20 : 8'($random(seed));
      e = (i == 1) ? 4'h8 : 4'($random(seed));
      pin <= 8'($random(seed));
      wb(1, 8'h04, {24'h0, c1});
      wb(1, 8'h00, {28'h2, e});
      `CHK(isel, c1[7:5])
      `CHK(esel, e)
      `CHK(econ, c1[7:5] inside {3'd0, 3'd5, 3'd6, 3'd7} && !e[3])
      `CHK(iod, pin)
      `CHK(puo, pin)
    end
    wb(1, 8'h04, 0);
    for (int f = 0; f < 2; f++) begin
      c = 8'h20 | 8'(f << 4) | 8'($random(seed) & 7);
      wb(1, 8'h00, {24'h0, c});
      conv(c);
      wb(0, 8'h00, 0);
      wb(0, 8'h00, 0);
      `CHK(q[6], 1'b1)
      repeat (20) @(posedge clk);
      wb(0, 8'h00, 0);
      `CHK(q[7:0], c)
      x = fmt(f[0], res);
      wb(0, 8'h18, 0);
      `CHK(q, {24'h0, x[15:8]})
      wb(0, 8'h1c, 0);
      `CHK(q, {24'h0, x[7:0]})
      `CHK(irq, 1'b0)
    end
    // Status stays sticky while masked, then the enable lets it through.
    wb(0, 8'h28, 0);
    `CHK(q[0], 1'b1)
    wb(1, 8'h2c, 32'h1);
    `CHK(irq, 1'b1)
    wb(1, 8'h30, 32'h1);
    `CHK(irq, 1'b0)
    conv(8'h10);
    repeat (20) @(posedge clk);
    `CHK(pwr, 1'b0)
    wb(0, 8'h18, 0);
    `CHK(q, {24'h0, x[15:8]})
    wb(1, 8'h08, 32'h20);
    wb(1, 8'h00, 32'h20);
    wb(0, 8'h00, 0);
    `CHK(q[4], 1'b1)
    conv(8'h20);
    wb(0, 8'h00, 0);
    wb(0, 8'h00, 0);
    `CHK(q[6], 1'b0)
    wb(1, 8'h0c, 32'h23);
    wb(1, 8'h10, 32'h05);
    wb(1, 8'h14, 32'h01);
    wb(1, 8'h08, 32'ha0);
    `CHK(esel, 4'h3)
    s0 = starts;
    blank <= 1;
    @(posedge clk);
    blank <= 0;
    repeat (120) @(posedge clk);
    `CHK(starts - s0, 2)
    `CHK(ch_at[s0[3:0]], 4'h3)
    `CHK(ch_at[4'(s0 + 1)], 4'h5)
    `CHK(t_at[4'(s0 + 1)] - t_at[s0[3:0]] >= 32, 1'b1)
    wb(0, 8'h24, 0);
    `CHK(q, {20'h0, res})
    wb(0, 8'h08, 0);
    `CHK(q[7], 1'b0)
    // Switching the converter off mid-conversion must keep the old result.
    wb(1, 8'h08, 0);
    wb(0, 8'h18, 0);
    x[7:0] = q[7:0];
    conv(8'h20);
    wb(1, 8'h00, 0);
    repeat (20) @(posedge clk);
    wb(0, 8'h00, 0);
    `CHK(q[6], 1'b0)
    wb(0, 8'h18, 0);
    `CHK(q[7:0], x[7:0])
    end_of_test;
  end
endmodule
`default_nettype wire
